// ### dv/test_timer_control_and_trigger.sv
`timescale 1ns/10ps
module test_timer_control_and_trigger;
   import tmr_pkg::*;

`define chk(nm, e, g) begin compares++; if ((g) !== (e)) begin \
   n_mismatch++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

   typedef struct packed {
      logic [31:0] ctl;
      logic [4:0]  trg;
      logic        irq;
   } row_t;

   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h0, hrdata, rdat, a, b;
   logic        hready, hresp, debug_halt = 1'b0, ev_drv = 1'b0;
   logic        cap_drv = 1'b0, clr = 1'b0, long_pulse;
   logic        event_pin_in, event_pin_out, event_pin_oe, e0;
   logic        capture_pin_in, capture_pin_out, capture_pin_oe;
   logic        timer_irq, wakeup_req;
   trig_t       trig_out;
   logic [4:0][7:0] n_pulse;
   int          n_mismatch = 0, compares = 0;
   row_t        rows [8] = '{
      '{32'h6800_0100, 5'h10, 1'b1}, '{32'h6800_0200, 5'h08, 1'b1},
      '{32'h6808_0000, 5'h04, 1'b1}, '{32'h6810_0000, 5'h02, 1'b1},
      '{32'h6820_0000, 5'h01, 1'b1}, '{32'h4838_0300, 5'h00, 1'b0},
      '{32'h7838_0300, 5'h1f, 1'b1}, '{32'h6038_0300, 5'h1f, 1'b1}};

   assign event_pin_in   = event_pin_oe ? event_pin_out : ev_drv;
   assign capture_pin_in = capture_pin_oe ? capture_pin_out : cap_drv;

   timer_control_and_trigger DUT (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hready), .hresp(hresp), .debug_halt(debug_halt),
      .event_pin_in(event_pin_in), .capture_pin_in(capture_pin_in),
      .event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe),
      .capture_pin_out(capture_pin_out), .capture_pin_oe(capture_pin_oe),
      .timer_irq(timer_irq), .wakeup_req(wakeup_req), .trig_out(trig_out));

   trig_consumer consumer (.hclk(hclk), .hresetn(hresetn), .clr(clr),
      .trig(trig_out), .n_pulse(n_pulse), .long_pulse(long_pulse));

   initial begin
      forever #20 hclk = ~hclk;
   end

   // ----------------------------------------------------------------
   // Bus and helper tasks
   // ----------------------------------------------------------------
   task automatic xfer(input logic w, input logic [7:0] ad,
                       input logic [31:0] wd);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= ad;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
      xfer(1'b1, ad, wd);
   endtask

   task automatic rd(input logic [7:0] ad);
      xfer(1'b0, ad, 32'h0);
   endtask

   // Polls instead of counting cycles, since the match latency is free.
   task automatic wait_tout();
      int k;
      k = 0;
      do begin
         rd(OFS_INTSTS);
         k++;
      end while (rdat[B_TOUT] !== 1'b1 && k < 300);
   endtask

   task automatic clr_p();
      clr <= 1'b1;
      @(posedge hclk);
      clr <= 1'b0;
   endtask

   task automatic results();
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #(40 * 20000);
      n_mismatch++;
      results();
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      repeat (6) @(posedge hclk);
      `chk("irq_rst", 1'b0, timer_irq)
      `chk("trig_rst", 5'h00, trig_out)
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(OFS_CTL);
      `chk("ctl_rst", CTL_RESET, rdat)
      for (int o = 4; o <= 24; o += 4) begin
         rd(8'(o));
         `chk("reg_rst", 32'h0, rdat)
      end
      wr(8'h40, 32'hffff_ffff);
      rd(8'h40);
      `chk("unmapped", 32'h0, rdat)
      wr(OFS_CNT, 32'h00ff_ffff);
      rd(OFS_CNT);
      `chk("cnt_ro", 32'h0, rdat)
      for (int i = 0; i < 8; i++) begin
         wr(OFS_CMP, 32'h10);
         wr(OFS_CTL, rows[i].ctl);
         wait_tout();
         repeat (4) @(posedge hclk);
         for (int j = 0; j < 5; j++)
            `chk("trig", rows[i].trg[j] ? 8'h01 : 8'h00, n_pulse[j])
         `chk("irq", rows[i].irq, timer_irq)
         wr(OFS_CTL, 32'h0);
         wr(OFS_INTSTS, 32'h1);
         rd(OFS_INTSTS);
         `chk("tif_w1c", 32'h0, rdat)
         clr_p();
      end
      wr(OFS_CMP, 32'h10);
      wr(OFS_CTL, 32'h6000_0000);
      rd(OFS_CTL);
      `chk("active", 1'b1, rdat[B_ACT])
      wait_tout();
      rd(OFS_CTL);
      `chk("oneshot", 2'b00, {rdat[B_RUN_EN], rdat[B_ACT]})
      wr(OFS_INTSTS, 32'h1);
      wr(OFS_CMP, 32'h00ff_ffff);
      wr(OFS_CTL, 32'h4800_0000);
      repeat (20) @(posedge hclk);
      wr(OFS_CTL, 32'h0800_0000);
      rd(OFS_CNT);
      a = rdat;
      repeat (10) @(posedge hclk);
      rd(OFS_CNT);
      `chk("suspend", a, rdat)
      wr(OFS_CTL, 32'h4800_0000);
      repeat (10) @(posedge hclk);
      rd(OFS_CNT);
      `chk("resume", 1'b1, rdat > a && a != 0)
      wr(OFS_CTL, 32'h4c00_0000);
      rd(OFS_CTL);
      `chk("clr_en", 1'b0, rdat[B_RUN_EN])
      rd(OFS_CNT);
      `chk("clr_cnt", 32'h0, rdat)
      debug_halt <= 1'b1;
      for (int u = 0; u < 2; u++) begin
         wr(OFS_MISC, 32'(u));
         wr(OFS_CTL, 32'hc800_0000);
         rd(OFS_CNT);
         a = rdat;
         repeat (10) @(posedge hclk);
         rd(OFS_CNT);
         `chk("dbg_halt", u[0], rdat != a)
      end
      debug_halt <= 1'b0;
      wr(OFS_CTL, 32'h0000_0003);
      wr(OFS_MISC, 32'h0);
      wr(OFS_CMP, 32'h00ff_ffff);
      wr(OFS_CTL, 32'h4800_0003);
      repeat (80) @(posedge hclk);
      wr(OFS_CTL, 32'h0800_0003);
      rd(OFS_CNT);
      `chk("prescale", 1'b1, rdat >= 18 && rdat <= 22)
      wr(OFS_CTL, 32'h0);
      clr_p();
      wr(OFS_EXTCTL, 32'h0000_000a);
      wr(OFS_CTL, 32'h003c_0300);
      cap_drv <= 1'b1;
      repeat (8) @(posedge hclk);
      for (int j = 0; j < 5; j++)
         `chk("cap_trig", 8'h01, n_pulse[j])
      rd(OFS_EINTST);
      `chk("cap_flag", 32'h1, rdat)
      wr(OFS_CTL, 32'h0);
      wr(OFS_EINTST, 32'h1);
      wr(OFS_MISC, 32'h2);
      wr(OFS_CMP, 32'h10);
      wr(OFS_CTL, 32'h6880_0000);
      wait_tout();
      repeat (4) @(posedge hclk);
      `chk("wake_req", 1'b1, wakeup_req)
      rd(OFS_INTSTS);
      `chk("wake_flag", 32'h3, rdat)
      wr(OFS_CTL, 32'h0);
      wr(OFS_INTSTS, 32'h3);
      wr(OFS_MISC, 32'h0);
      wr(OFS_EXTCTL, 32'h0000_0001);
      wr(OFS_CMP, 32'h10);
      wr(OFS_CTL, 32'h4900_0000);
      repeat (4) begin
         ev_drv <= 1'b1;
         repeat (2) @(posedge hclk);
         ev_drv <= 1'b0;
         repeat (2) @(posedge hclk);
      end
      repeat (4) @(posedge hclk);
      rd(OFS_CNT);
      `chk("ev_count", 32'h4, rdat)
      wr(OFS_CMP, 32'h10);
      wr(OFS_CTL, 32'h5000_0000);
      repeat (4) @(posedge hclk);
      `chk("tgl_ev", 2'b10, {event_pin_oe, capture_pin_oe})
      e0 = event_pin_out;
      repeat (16) @(posedge hclk);
      `chk("tgl_out", ~e0, event_pin_out)
      wr(OFS_CTL, 32'h5040_0000);
      repeat (2) @(posedge hclk);
      `chk("tgl_cap", 2'b01, {event_pin_oe, capture_pin_oe})
      `chk("pulse_len", 1'b0, long_pulse)
      e0 = capture_pin_out;
      repeat (16) @(posedge hclk);
      `chk("tgl_cap_out", ~e0, capture_pin_out)
      `chk("hresp", 1'b0, hresp)
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      `chk("oe_rst", 2'b00, {event_pin_oe, capture_pin_oe})
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(OFS_CTL);
      `chk("ctl_rst2", CTL_RESET, rdat)
      results();
   end
endmodule // test_timer_control_and_trigger

// ### dv/trig_consumer.sv
`timescale 1ns/10ps
module trig_consumer
   import tmr_pkg::*;
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       clr,
   input  wire trig_t      trig,
   output logic [4:0][7:0] n_pulse,
   output logic            long_pulse
);
   // Consumers act on each rising edge, so a request held high for two
   // cycles would merge two events and hide a lost one.
   logic [4:0] now_v;
   logic [4:0] last_v;

   assign now_v = trig;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_v     <= '0;
         n_pulse    <= '0;
         long_pulse <= 1'b0;
      end else begin
         last_v <= now_v;
         for (int i = 0; i < 5; i++) begin
            if (clr)
               n_pulse[i] <= 8'h00;
            else if (now_v[i] && !last_v[i])
               n_pulse[i] <= n_pulse[i] + 8'h01;
         end
         if (|(now_v & last_v))
            long_pulse <= 1'b1;
      end
   end
endmodule // trig_consumer

// ### hdl/pin_sync.sv
`timescale 1ns/10ps
module pin_sync
   import tmr_pkg::*;
#(
   parameter int WIDTH = 2
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta_reg;

   // Only the second stage is visible; the first may be metastable.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end

endmodule // pin_sync

// ### hdl/timer_control_and_trigger.sv
`timescale 1ns/10ps
// Functional notes
// RL1: Trigger source: timeout at select 0, else capture. The code uses the timeout only with the interrupt enable set (irq_now).
// RL2: DMA request when enabled and event occurs.
// RL3: Basic PWM trigger pulse on enabled event.
// RL4: PWM trigger pulse on enabled event.
// RL5: DAC start pulse on enabled event.
// RL6: ADC start pulse on enabled event.
// RL7: Counter freezes in debug halt unless bit set.
// RL8: Mode field: oneshot, periodic, toggle, continuous.
// RL9: Count enable clear suspends; set resumes held value.
// RL10: One-shot clears count enable when timeout sets.
// RL11: Interrupt equals timeout flag and interrupt enable.
// RL12: Counter clear resets prescaler, counter, count enable.
// RL13: Active bit shows counter running.
// RL14: Software picks bus clock for event counting.
// RL15: Wake trigger when wake, flag, interrupt enable.
// RL16: Wake flag sets on interrupt during power-down.
// RL17: Toggle output goes to event or capture pin.
// RL18: Prescaler divides by value plus one.
// RL19: Timeout flag sets on compare match; write-one clears.
// RL20: Each trigger is one pulse per rising event.
module timer_control_and_trigger
   import tmr_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        debug_halt,
   input  wire logic        event_pin_in,
   input  wire logic        capture_pin_in,
   output logic             event_pin_out,
   output logic             event_pin_oe,
   output logic             capture_pin_out,
   output logic             capture_pin_oe,
   output logic             timer_irq,
   output logic             wakeup_req,
   output trig_t            trig_out
);

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [31:0] ctl_reg;
   logic [23:0] cmp_reg;
   logic        tout_reg;
   logic        wkf_reg;
   logic [23:0] cnt_reg;
   logic [23:0] cap_reg;
   logic [7:0]  ext_reg;
   logic        capf_reg;
   logic [1:0]  misc_reg;
   logic [7:0]  prediv_reg;
   logic        tgl_reg;
   logic        src_prev_reg;
   logic [1:0]  pin_s;
   logic        ev_prev_reg;
   logic        cap_prev_reg;
   logic        wr_pend_reg;
   logic [7:0]  wr_addr_reg;

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   pin_sync #(.WIDTH(2)) u_sync (
      .hclk    (hclk),
      .hresetn (hresetn),
      .d       ({capture_pin_in, event_pin_in}),
      .q       (pin_s)
   );

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   wire       addr_ok = hsel && hready && htrans[1];
   wire       wr_ph   = addr_ok && hwrite;
   wire       rd_ph   = addr_ok && !hwrite;
   wire       wr_ctl  = wr_pend_reg && wr_addr_reg == OFS_CTL;
   wire       wr_cmp  = wr_pend_reg && wr_addr_reg == OFS_CMP;
   wire       wr_ist  = wr_pend_reg && wr_addr_reg == OFS_INTSTS;
   wire       wr_ext  = wr_pend_reg && wr_addr_reg == OFS_EXTCTL;
   wire       wr_eist = wr_pend_reg && wr_addr_reg == OFS_EINTST;
   wire       wr_misc = wr_pend_reg && wr_addr_reg == OFS_MISC;

   // -----------------------------------------------------------------
   // Counter datapath
   // -----------------------------------------------------------------
   wire       unlocked = misc_reg[B_UNLOCK];
   wire       run_en   = ctl_reg[B_RUN_EN];
   wire [1:0] mode_raw = ctl_reg[B_MODEH:B_MODEL];
   op_mode_t  mode;
   assign mode = op_mode_t'(mode_raw);                            // RL8
   wire       evcnt    = ctl_reg[B_EVCNT];
   wire       halted   = debug_halt && !ctl_reg[B_DBG];           // RL7
   wire       run      = run_en && !halted;                       // RL9
   wire       ev_sel   = ext_reg[0] ? (pin_s[0] && !ev_prev_reg)
                                    : (!pin_s[0] && ev_prev_reg);
   // Event counting uses a qualified pin edge as the count tick.
   wire       tick_src = evcnt ? ev_sel : 1'b1;
   wire       psc_hit  = run && tick_src
                         && prediv_reg == ctl_reg[7:0];           // RL18
   wire [23:0] cnt_inc = cnt_reg + 24'h000001;
   wire       match    = psc_hit && cnt_inc == cmp_reg;           // RL19
   wire       clr_req  = wr_ctl && hwdata[B_CLR];                 // RL12
   wire [1:0] cap_edge = ext_reg[2:1];
   wire       cap_rise = pin_s[1] && !cap_prev_reg;
   wire       cap_fall = !pin_s[1] && cap_prev_reg;
   wire       cap_ev   = ext_reg[B_CAPEN] && (
                         (cap_edge == 2'b00 && cap_fall) ||
                         (cap_edge == 2'b01 && cap_rise) ||
                         (cap_edge == 2'b10 && (cap_rise || cap_fall)));
   wire       cap_load = cap_ev && !ext_reg[B_CAPFN] && !capf_reg;
   wire       cap_rst  = cap_ev && ext_reg[B_CAPFN];

   // -----------------------------------------------------------------
   // Interrupt, wake and trigger routing
   // -----------------------------------------------------------------
   wire       irq_now  = tout_reg && ctl_reg[B_IRQ_EN];           // RL11
   wire       wake_now = irq_now && ctl_reg[B_WAKE];              // RL15
   wire       src_lvl  = ctl_reg[B_SRC] ? capf_reg : irq_now;     // RL1
   wire       src_rise = src_lvl && !src_prev_reg;                // RL20
   trig_t     trig_next;
   assign trig_next.dma  = src_rise && ctl_reg[B_DMA];            // RL2
   assign trig_next.bpwm = src_rise && ctl_reg[B_BPWM];           // RL3
   assign trig_next.pwm  = src_rise && ctl_reg[B_PWM];            // RL4
   assign trig_next.dac  = src_rise && ctl_reg[B_DAC];            // RL5
   assign trig_next.adc  = src_rise && ctl_reg[B_ADC];            // RL6

   // -----------------------------------------------------------------
   // Control register next value
   // -----------------------------------------------------------------
   logic [31:0] ctl_next;
   always_comb begin
      ctl_next = ctl_reg;
      if (wr_ctl) begin
         ctl_next = hwdata;
         ctl_next[B_ACT] = 1'b0;
         ctl_next[B_CLR] = 1'b0;
         ctl_next[17:10] = 8'h00;
         if (!unlocked) begin
            ctl_next[B_DBG] = ctl_reg[B_DBG];                     // RL7
         end
         if (hwdata[B_CLR] && ctl_reg[B_ACT]) begin
            ctl_next[B_RUN_EN] = 1'b0;                            // RL12
         end
      end
      if (match && mode == MODE_ONESHOT) begin
         ctl_next[B_RUN_EN] = 1'b0;                               // RL10
      end
      ctl_next[B_ACT] = ctl_next[B_RUN_EN];                       // RL13
   end

   // -----------------------------------------------------------------
   // Bus slave
   // -----------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      case (haddr)
         OFS_CTL:    rd_mux = ctl_reg;
         OFS_CMP:    rd_mux = {8'h00, cmp_reg};
         OFS_INTSTS: rd_mux = {30'h0, wkf_reg, tout_reg};
         OFS_CNT:    rd_mux = {8'h00, cnt_reg};
         OFS_CAP:    rd_mux = {8'h00, cap_reg};
         OFS_EXTCTL: rd_mux = {24'h0, ext_reg};
         OFS_EINTST: rd_mux = {31'h0, capf_reg};
         OFS_MISC:   rd_mux = {30'h0, misc_reg};
         default:    rd_mux = 32'h0000_0000;
      endcase
   end

   // Writes land at the end of the data phase; zero wait states.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         wr_pend_reg <= wr_ph;
         wr_addr_reg <= haddr;
         if (rd_ph) begin
            hrdata <= rd_mux;
         end
      end
   end

   // -----------------------------------------------------------------
   // Control and status state
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctl_reg  <= CTL_RESET;
         cmp_reg  <= 24'h000000;
         ext_reg  <= 8'h00;
         misc_reg <= 2'b00;
      end else begin
         ctl_reg <= ctl_next;
         if (wr_cmp) begin
            cmp_reg <= hwdata[23:0];
         end
         if (wr_ext) begin
            ext_reg <= hwdata[7:0];
         end
         if (wr_misc) begin
            misc_reg <= hwdata[1:0];
         end
      end
   end

   // Flags: a hardware set in the same cycle as a write-one clear wins.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tout_reg <= 1'b0;
         wkf_reg  <= 1'b0;
         capf_reg <= 1'b0;
      end else begin
         tout_reg <= match || (tout_reg
                     && !(wr_ist && hwdata[B_TOUT]));             // RL19
         wkf_reg  <= (wake_now && misc_reg[B_PD]) || (wkf_reg
                     && !(wr_ist && hwdata[B_WKF]));              // RL16
         capf_reg <= cap_load || (capf_reg
                     && !(wr_eist && hwdata[B_CAPF]));
      end
   end

   // -----------------------------------------------------------------
   // Prescaler, counter, capture, toggle
   // -----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         prediv_reg   <= 8'h00;
         cnt_reg      <= 24'h000000;
         cap_reg      <= 24'h000000;
         tgl_reg      <= 1'b0;
         ev_prev_reg  <= 1'b0;
         cap_prev_reg <= 1'b0;
      end else begin
         ev_prev_reg  <= pin_s[0];
         cap_prev_reg <= pin_s[1];
         if (cap_load) begin
            cap_reg <= cnt_reg;
         end
         if (clr_req || cap_rst ||
             (wr_cmp && mode != MODE_CONT)) begin
            prediv_reg <= 8'h00;                                  // RL12
            cnt_reg     <= 24'h000000;
         end else if (run && tick_src) begin
            if (psc_hit) begin
               prediv_reg <= 8'h00;                               // RL18
               if (match && mode != MODE_CONT) begin
                  cnt_reg <= 24'h000000;                          // RL8
               end else begin
                  cnt_reg <= cnt_inc;
               end
            end else begin
               prediv_reg <= prediv_reg + 8'h01;
            end
         end
         if (match && mode == MODE_TOGGLE) begin
            tgl_reg <= !tgl_reg;
         end
      end
   end

   // -----------------------------------------------------------------
   // Registered outputs
   // -----------------------------------------------------------------
   wire tgl_on = mode == MODE_TOGGLE && !evcnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_prev_reg    <= 1'b0;
         trig_out        <= '0;
         timer_irq       <= 1'b0;
         wakeup_req      <= 1'b0;
         event_pin_out   <= 1'b0;
         event_pin_oe    <= 1'b0;
         capture_pin_out <= 1'b0;
         capture_pin_oe  <= 1'b0;
      end else begin
         src_prev_reg    <= src_lvl;
         trig_out        <= trig_next;                            // RL20
         timer_irq       <= irq_now;                              // RL11
         wakeup_req      <= wake_now;                             // RL15
         event_pin_out   <= tgl_reg;
         capture_pin_out <= tgl_reg;
         event_pin_oe    <= tgl_on && !ctl_reg[B_TGLSEL];         // RL17
         capture_pin_oe  <= tgl_on && ctl_reg[B_TGLSEL];          // RL17
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   a_irq_follows: assert property (@(posedge hclk)                 // RL11
      disable iff (!hresetn)
      timer_irq == $past(tout_reg && ctl_reg[B_IRQ_EN]))
      else $error("timer_irq does not follow flag and enable");
   a_wake_follows: assert property (@(posedge hclk)                // RL15
      disable iff (!hresetn)
      wakeup_req == $past(tout_reg && ctl_reg[B_IRQ_EN] && ctl_reg[B_WAKE]))
      else $error("wakeup_req does not follow its enables");
   a_oneshot_stop: assert property (@(posedge hclk)                // RL10
      disable iff (!hresetn)
      (match && mode == MODE_ONESHOT) |=> !ctl_reg[B_RUN_EN])
      else $error("one-shot did not clear count enable");
   a_tout_set: assert property (@(posedge hclk)                    // RL19
      disable iff (!hresetn)
      match |=> tout_reg)
      else $error("timeout flag not set on match");
   a_trig_once: assert property (@(posedge hclk)                   // RL20
      disable iff (!hresetn)
      trig_out.adc |=> !trig_out.adc)
      else $error("adc trigger longer than one cycle");
   a_dma_route: assert property (@(posedge hclk)                   // RL2
      disable iff (!hresetn)
      (src_rise && ctl_reg[B_DMA]) |=> trig_out.dma)
      else $error("dma request missing");
   a_dac_route: assert property (@(posedge hclk)                   // RL5
      disable iff (!hresetn)
      (src_rise && ctl_reg[B_DAC]) |=> trig_out.dac)
      else $error("dac start pulse missing");
   a_trig_src: assert property (@(posedge hclk)                    // RL1
      disable iff (!hresetn)
      (ctl_reg[B_SRC] && !capf_reg) |=> !trig_out.pwm)
      else $error("pwm trigger from wrong source");
   a_active_sts: assert property (@(posedge hclk)                  // RL13
      disable iff (!hresetn)
      ctl_reg[B_ACT] == ctl_reg[B_RUN_EN])
      else $error("active status mismatch");
   a_halt_hold: assert property (@(posedge hclk)                   // RL7
      disable iff (!hresetn)
      (halted && !clr_req && !cap_rst && !wr_cmp) |=>
      cnt_reg == $past(cnt_reg))
      else $error("counter moved during debug halt");
   a_suspend_hold: assert property (@(posedge hclk)                // RL9
      disable iff (!hresetn)
      (!run_en && !clr_req && !cap_rst && !wr_cmp) |=> $stable(cnt_reg))
      else $error("counter moved while suspended");
   a_clr_count: assert property (@(posedge hclk)                   // RL12
      disable iff (!hresetn)
      clr_req |=> cnt_reg == 24'h000000 && prediv_reg == 8'h00)
      else $error("counter clear failed");

endmodule // timer_control_and_trigger

// ### hdl/tmr_pkg.sv
package tmr_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTL    = 8'h00;
   localparam logic [7:0] OFS_CMP    = 8'h04;
   localparam logic [7:0] OFS_INTSTS = 8'h08;
   localparam logic [7:0] OFS_CNT    = 8'h0c;
   localparam logic [7:0] OFS_CAP    = 8'h10;
   localparam logic [7:0] OFS_EXTCTL = 8'h14;
   localparam logic [7:0] OFS_EINTST = 8'h18;
   localparam logic [7:0] OFS_MISC   = 8'h1c;

   localparam logic [31:0] CTL_RESET = 32'h0000_0005;

   // -----------------------------------------------------------------
   // Register field positions
   // -----------------------------------------------------------------
   localparam int B_DBG    = 31;
   localparam int B_RUN_EN = 30;
   localparam int B_IRQ_EN = 29;
   localparam int B_MODEH  = 28;
   localparam int B_MODEL  = 27;
   localparam int B_CLR    = 26;
   localparam int B_ACT    = 25;
   localparam int B_EVCNT  = 24;
   localparam int B_WAKE   = 23;
   localparam int B_TGLSEL = 22;
   localparam int B_ADC    = 21;
   localparam int B_DAC    = 20;
   localparam int B_PWM    = 19;
   localparam int B_SRC    = 18;
   localparam int B_BPWM   = 9;
   localparam int B_DMA    = 8;
   localparam int B_TOUT   = 0;
   localparam int B_WKF    = 1;
   localparam int B_CAPEN  = 3;
   localparam int B_CAPFN  = 4;
   localparam int B_CAPF   = 0;
   localparam int B_UNLOCK = 0;
   localparam int B_PD     = 1;

   typedef enum logic [1:0] {
      MODE_ONESHOT,
      MODE_PERIODIC,
      MODE_TOGGLE,
      MODE_CONT
   } op_mode_t;

   typedef struct packed {
      logic dma;
      logic bpwm;
      logic pwm;
      logic dac;
      logic adc;
   } trig_t;

endpackage
